//--- core/lbl_pkg.sv
package lbl_pkg;

  localparam logic [7:0] LADDER_OFS   = 8'h00;
  localparam logic [7:0] REFCTL_OFS   = 8'h04;
  localparam logic [7:0] DISPCFG_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0c;

  localparam logic [7:0] LADDER_RST   = 8'h00;
  localparam logic [7:0] REFCTL_RST   = 8'h00;
  localparam logic [7:0] DISPCFG_RST  = 8'h00;
  localparam logic [7:0] LADDER_WMASK = 8'hf7;

  // ladder control fields
  localparam int A_POW_LSB  = 6;
  localparam int B_POW_LSB  = 4;
  localparam int A_CNT_LSB  = 0;
  // bias reference control fields
  localparam int REF_EN_BIT = 0;
  localparam int REF_SRC_BIT = 1;
  localparam int GATE_BIT   = 2;
  localparam int PIN_LSB    = 3;
  // display configuration fields
  localparam int TAP_LSB    = 0;
  localparam int WFT_BIT    = 3;

  // 32 kHz clocks per segment interval
  localparam logic [4:0] SPAN_TYPE_A = 5'h10;
  localparam logic [4:0] SPAN_TYPE_B = 5'h00;
  localparam int         SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_LOW,
    PWR_MED,
    PWR_HIGH
  } lbl_power_t;

  typedef struct packed {
    lbl_power_t ladderPower;
    logic       ladderModeB;
    logic       contrastEnable;
    logic [2:0] contrastTapSelect;
    logic       internalRefEnable;
    logic       refFromFixedRef;
    logic       fixedRefBufferEnable;
    logic       fixedRefRequest;
    logic [2:0] externalBiasPins;
  } lbl_bias_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } lbl_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lbl_apb_rsp_t;

endpackage

//--- core/lbl_pin_sync.sv
`timescale 1ns/1ps
module lbl_pin_sync #(
  parameter int STAGES = 3
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise
);
  logic [STAGES-1:0] stage;

  // a change is accepted only once the last two stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage <= '0;
    end else begin
      stage <= {stage[STAGES-2:0], pinIn};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (stage[STAGES-2] == stage[STAGES-1] && stage[STAGES-1] != level) begin
        level <= stage[STAGES-1];
        rise  <= stage[STAGES-1];
      end
    end
  end
endmodule

//--- core/lbl_bias_ladder.sv
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module lbl_bias_ladder (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          slowClkPin,
  input  wire logic          lcdActiveFlag,
  input  lbl_pkg::lbl_apb_req_t apbReq,
  output lbl_pkg::lbl_apb_rsp_t apbRsp,
  output lbl_pkg::lbl_bias_t    biasCtl
);
  import lbl_pkg::*;

  logic [7:0] ladderReg;
  logic [7:0] refReg;
  logic [7:0] cfgReg;
  logic [4:0] prescaler;
  logic       slowLevel;
  logic       slowTick;
  logic [31:0] prdataReg;
  logic        slvErr;

  logic       setupPhase;
  logic       accessPhase;
  logic       hitLadder;
  logic       hitRef;
  logic       hitCfg;
  logic       hitStatus;
  logic       mapped;

  lbl_power_t aPower;
  lbl_power_t bPower;
  logic [2:0] aCount;
  logic       waveTypeB;
  logic [4:0] spanLast;
  logic       inModeA;
  lbl_bias_t  next_bias;

  lbl_pin_sync #(
    .STAGES (SYNC_STAGES)
  ) u_slow_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pinIn   (slowClkPin),
    .level   (slowLevel),
    .rise    (slowTick)
  );

  // ---------------- apb slave ----------------
  assign setupPhase  = apbReq.psel && !apbReq.penable;
  assign accessPhase = apbReq.psel && apbReq.penable;
  assign hitLadder   = apbReq.paddr == LADDER_OFS;
  assign hitRef      = apbReq.paddr == REFCTL_OFS;
  assign hitCfg      = apbReq.paddr == DISPCFG_OFS;
  assign hitStatus   = apbReq.paddr == STATUS_OFS;
  assign mapped      = hitLadder || hitRef || hitCfg || hitStatus;

  // zero wait states: read data is latched in the setup cycle
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = slvErr;
  assign apbRsp.prdata  = prdataReg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      slvErr <= 1'b0;
    end else if (setupPhase) begin
      // status is read only, so a write to it is refused
      slvErr <= !mapped || (apbReq.pwrite && hitStatus);
    end else if (accessPhase) begin
      slvErr <= slvErr;
    end else begin
      slvErr <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdataReg <= 32'h0000_0000;
    end else if (setupPhase && !apbReq.pwrite) begin
      prdataReg <= 32'h0000_0000;
      if (hitLadder) begin
        prdataReg[7:0] <= ladderReg;
      end else if (hitRef) begin
        prdataReg[7:0] <= refReg;
      end else if (hitCfg) begin
        prdataReg[7:0] <= cfgReg;
      end else if (hitStatus) begin
        prdataReg[15:0] <= {3'h0, prescaler,
                            biasCtl.fixedRefBufferEnable,
                            biasCtl.fixedRefRequest,
                            biasCtl.internalRefEnable,
                            biasCtl.contrastEnable,
                            biasCtl.ladderModeB,
                            biasCtl.ladderPower,
                            lcdActiveFlag};
      end
    end
  end

  // bit 3 of the ladder register is unimplemented and stays zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ladderReg <= LADDER_RST;
    end else if (accessPhase && apbReq.pwrite && hitLadder) begin
      ladderReg <= apbReq.pwdata[7:0] & LADDER_WMASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      refReg <= REFCTL_RST;
    end else if (accessPhase && apbReq.pwrite && hitRef) begin
      refReg <= {2'h0, apbReq.pwdata[5:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfgReg <= DISPCFG_RST;
    end else if (accessPhase && apbReq.pwrite && hitCfg) begin
      cfgReg <= {4'h0, apbReq.pwdata[3:0]};
    end
  end

  // ---------------- interval timing ----------------
  assign aPower    = lbl_power_t'(ladderReg[A_POW_LSB +: 2]);
  assign bPower    = lbl_power_t'(ladderReg[B_POW_LSB +: 2]);
  assign aCount    = ladderReg[A_CNT_LSB +: 3];
  assign waveTypeB = cfgReg[WFT_BIT];
  // span of 32 counts wraps the 5-bit prescaler naturally
  assign spanLast  = (waveTypeB ? SPAN_TYPE_B : SPAN_TYPE_A) - 5'h01;

  // the prescaler restarts whenever the display goes idle, so the
  // first interval after activation begins with a fresh transition
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prescaler <= 5'h00;
    end else if (!lcdActiveFlag) begin
      prescaler <= 5'h00;
    end else if (slowTick) begin
      if (prescaler >= spanLast) begin
        prescaler <= 5'h00;
      end else begin
        prescaler <= prescaler + 5'h01;
      end
    end
  end

  // phase 0 is the transition; A holds for aCount slow clocks
  assign inModeA = (aCount != 3'h0) && (prescaler < {2'h0, aCount});

  // ---------------- bias outputs ----------------
  always_comb begin
    next_bias = '0;
    next_bias.externalBiasPins  = refReg[PIN_LSB +: 3];
    next_bias.internalRefEnable = lcdActiveFlag && refReg[REF_EN_BIT];
    next_bias.refFromFixedRef   = refReg[REF_SRC_BIT];
    next_bias.ladderModeB       = !inModeA;
    // pin enables deliberately play no part in the ladder power
    if (lcdActiveFlag) begin
      next_bias.ladderPower = inModeA ? aPower : bPower;
    end else begin
      next_bias.ladderPower = PWR_OFF;
    end
    next_bias.contrastEnable = next_bias.internalRefEnable;
    if (next_bias.contrastEnable) begin
      // taps 000..111 step the source down, 111 is about -10 percent
      next_bias.contrastTapSelect = cfgReg[TAP_LSB +: 3];
    end
    next_bias.fixedRefRequest = next_bias.internalRefEnable
                                && refReg[REF_SRC_BIT];
    next_bias.fixedRefBufferEnable = next_bias.fixedRefRequest
                                     && !(refReg[GATE_BIT]
                                          && next_bias.ladderModeB);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      biasCtl <= '0;
    end else begin
      biasCtl <= next_bias;
    end
  end

  // ---------------- checks ----------------
  property p_ladder_off_idle;
    @(posedge ref_clk) disable iff (rst)
    !lcdActiveFlag |=> biasCtl.ladderPower == PWR_OFF;
  endproperty
  a_ladder_off_idle: assert property (p_ladder_off_idle)
    else $error("ladder powered while lcd idle");

  property p_ref_off_idle;
    @(posedge ref_clk) disable iff (rst)
    !lcdActiveFlag |=> !biasCtl.internalRefEnable && !biasCtl.contrastEnable
                       && !biasCtl.fixedRefRequest;
  endproperty
  a_ref_off_idle: assert property (p_ref_off_idle)
    else $error("reference or contrast on while lcd idle");

  property p_contrast_needs_ref;
    @(posedge ref_clk) disable iff (rst)
    biasCtl.contrastEnable |-> biasCtl.internalRefEnable;
  endproperty
  a_contrast_needs_ref: assert property (p_contrast_needs_ref)
    else $error("contrast ladder on without internal reference");

  property p_contrast_open;
    @(posedge ref_clk) disable iff (rst)
    !biasCtl.contrastEnable |-> biasCtl.contrastTapSelect == 3'h0;
  endproperty
  a_contrast_open: assert property (p_contrast_open)
    else $error("contrast tap driven while ladder open");

  property p_buffer_gate;
    @(posedge ref_clk) disable iff (rst)
    (biasCtl.fixedRefRequest && biasCtl.ladderModeB && refReg[GATE_BIT]
     && $stable(refReg))
    |-> !biasCtl.fixedRefBufferEnable;
  endproperty
  a_buffer_gate: assert property (p_buffer_gate)
    else $error("fixed-ref buffer on in gated mode B");

  property p_fvr_auto;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && refReg[REF_EN_BIT] && refReg[REF_SRC_BIT])
    |=> biasCtl.fixedRefRequest;
  endproperty
  a_fvr_auto: assert property (p_fvr_auto)
    else $error("fixed reference not requested");

  property p_pins_independent;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && refReg[PIN_LSB +: 3] != 3'h0 && !inModeA)
    |=> biasCtl.ladderPower == $past(bPower);
  endproperty
  a_pins_independent: assert property (p_pins_independent)
    else $error("ladder not in selected B power");

  property p_mode_a_at_transition;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && prescaler == 5'h00 && aCount != 3'h0)
    ##1 lcdActiveFlag |-> !biasCtl.ladderModeB;
  endproperty
  a_mode_a_at_transition: assert property (p_mode_a_at_transition)
    else $error("mode A missing at segment transition");

  property p_prescaler_wrap;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && slowTick && prescaler == spanLast)
    |=> prescaler == 5'h00;
  endproperty
  a_prescaler_wrap: assert property (p_prescaler_wrap)
    else $error("prescaler did not wrap at interval end");

  property p_mode_b_after_count;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && prescaler >= {2'h0, aCount} && $stable(ladderReg))
    ##1 lcdActiveFlag |-> biasCtl.ladderModeB;
  endproperty
  a_mode_b_after_count: assert property (p_mode_b_after_count)
    else $error("mode A held beyond its count");

  property p_power_decode;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && !inModeA && $stable(ladderReg))
    |=> biasCtl.ladderPower == $past(bPower);
  endproperty
  a_power_decode: assert property (p_power_decode)
    else $error("power select decoded wrongly");

  property p_tap_follows;
    @(posedge ref_clk) disable iff (rst)
    (biasCtl.contrastEnable && $stable(cfgReg))
    |-> biasCtl.contrastTapSelect == cfgReg[TAP_LSB +: 3];
  endproperty
  a_tap_follows: assert property (p_tap_follows)
    else $error("contrast tap does not follow firmware field");

  property p_pins_follow;
    @(posedge ref_clk) disable iff (rst)
    $stable(refReg) |-> biasCtl.externalBiasPins == refReg[PIN_LSB +: 3];
  endproperty
  a_pins_follow: assert property (p_pins_follow)
    else $error("external pin enables do not follow register");

  property p_tick_level;
    @(posedge ref_clk) disable iff (rst)
    slowTick |-> slowLevel;
  endproperty
  a_tick_level: assert property (p_tick_level)
    else $error("slow clock tick without a high synchronised level");

  property p_prescaler_idle;
    @(posedge ref_clk) disable iff (rst)
    !lcdActiveFlag |=> prescaler == 5'h00;
  endproperty
  a_prescaler_idle: assert property (p_prescaler_idle)
    else $error("prescaler running while lcd idle");

  property p_prescaler_step;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && slowTick && prescaler < spanLast)
    |=> prescaler == $past(prescaler) + 5'h01;
  endproperty
  a_prescaler_step: assert property (p_prescaler_step)
    else $error("prescaler did not advance on a slow clock tick");

  property p_prescaler_hold;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && !slowTick) |=> $stable(prescaler);
  endproperty
  a_prescaler_hold: assert property (p_prescaler_hold)
    else $error("prescaler moved without a slow clock tick");

  property p_buffer_mode_a;
    @(posedge ref_clk) disable iff (rst)
    (biasCtl.fixedRefRequest && !biasCtl.ladderModeB) |-> biasCtl.fixedRefBufferEnable;
  endproperty
  a_buffer_mode_a: assert property (p_buffer_mode_a)
    else $error("fixed-ref buffer off during mode A");

  property p_source_follows;
    @(posedge ref_clk) disable iff (rst)
    $stable(refReg) |-> biasCtl.refFromFixedRef == refReg[REF_SRC_BIT];
  endproperty
  a_source_follows: assert property (p_source_follows)
    else $error("reference source does not follow register");

  property p_ref_enable_follows;
    @(posedge ref_clk) disable iff (rst)
    (lcdActiveFlag && refReg[REF_EN_BIT]) |=> biasCtl.internalRefEnable;
  endproperty
  a_ref_enable_follows: assert property (p_ref_enable_follows)
    else $error("internal reference not enabled while lcd active");

endmodule

//--- test/lbl_far_side_model.sv
`timescale 1ns/1ps
// slow lcd clock source seen from the far side; it stands low while run is low
// so that the bench knows exactly which edge starts each interval
module lbl_far_side_model #(
  parameter int HALF = 10
) (
  input  wire logic ref_clk,
  input  wire logic run,
  output logic      slowClkPin
);
  int count;

  initial begin
    slowClkPin = 1'b0;
    count = 0;
  end

  always @(posedge ref_clk) begin
    if (!run) begin
      count <= 0;
      slowClkPin <= 1'b0;
    end else if (count == HALF - 1) begin
      count <= 0;
      slowClkPin <= ~slowClkPin;
    end else begin
      count <= count + 1;
    end
  end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lbl_pkg::*;
  logic         ref_clk;
  logic         rst;
  logic         lcdActiveFlag;
  logic         run;
  logic         slowClkPin;
  lbl_apb_req_t apbReq;
  lbl_apb_rsp_t apbRsp;
  lbl_bias_t    biasCtl;
  int           err_count;
  int           num_checks;
  int           cycles;
  int           seed;
  logic [31:0]  rd;
  logic [31:0]  d;
  logic         e;

  lbl_bias_ladder lbl_bias_ladder_inst (.ref_clk(ref_clk), .rst(rst), .slowClkPin(slowClkPin),
    .lcdActiveFlag(lcdActiveFlag), .apbReq(apbReq), .apbRsp(apbRsp), .biasCtl(biasCtl));
  lbl_far_side_model lbl_far_side_model_inst (.ref_clk(ref_clk), .run(run),
    .slowClkPin(slowClkPin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ceiling well above the under two thousand cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // wait states are allowed: the access phase lasts until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic xe,
                        input string msg);
    apb(1'b0, a, 32'h0);
    check(rd, exp, msg);
    check({31'h0, e}, {31'h0, xe}, msg);
  endtask

  // outputs are registered one edge behind their cause
  task automatic wt();
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic set_lcd(input logic v);
    @(posedge ref_clk);
    lcdActiveFlag <= v;
    wt();
  endtask

  task automatic interval(input logic waveform_type_select, input logic [2:0] cnt, input logic gate,
                          input int ticks);
    logic [1:0] ap;
    logic [1:0] bp;
    logic       mb;
    int         p;
    ap = 2'($random(seed));
    bp = 2'($random(seed));
    apb(1'b1, LADDER_OFS, {24'($random(seed)), ap, bp, 1'b1, cnt});
    apb(1'b1, REFCTL_OFS, {26'h0, 3'b000, gate, 2'b11});
    apb(1'b1, DISPCFG_OFS, {28'h0, waveform_type_select, 3'b111});
    set_lcd(1'b1);
    check(32'(biasCtl.refFromFixedRef), 32'h1, "fixed source");
    check(32'(biasCtl.fixedRefRequest), 32'h1, "fixed request");
    for (int k = 0; k <= ticks; k++) begin
      p = k % (waveform_type_select ? 32 : 16);
      mb = (cnt == 3'd0) || (p >= int'(cnt));
      check(32'(biasCtl.ladderModeB), 32'(mb), "mode");
      check(32'(biasCtl.ladderPower), 32'(mb ? bp : ap), "power");
      check(32'(biasCtl.fixedRefBufferEnable), 32'(!(gate && mb)), "buffer");
      if (k == 0) begin
        @(posedge ref_clk);
        run <= 1'b1;
      end
      @(posedge slowClkPin);
      repeat (8) @(negedge ref_clk);
    end
    @(posedge ref_clk);
    run <= 1'b0;
    set_lcd(1'b0);
    check(32'(biasCtl.ladderPower), 32'h0, "inactive ladder");
    check(32'(biasCtl.internalRefEnable), 32'h0, "inactive ref");
    check(32'(biasCtl.contrastEnable), 32'h0, "inactive contrast");
    check(32'(biasCtl.fixedRefRequest), 32'h0, "inactive request");
    $display("test interval done");
  endtask

  initial begin
    seed = 32'h722d528b;
    rst = 1'b1;
    lcdActiveFlag = 1'b0;
    run = 1'b0;
    apbReq = '0;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(LADDER_OFS, 32'h0, 1'b0, "ladder reset");
    rd_chk(REFCTL_OFS, 32'h0, 1'b0, "refctl reset");
    rd_chk(DISPCFG_OFS, 32'h0, 1'b0, "config reset");
    rd_chk(STATUS_OFS, 32'h8, 1'b0, "status reset");
    d = $random(seed);
    apb(1'b1, LADDER_OFS, d);
    rd_chk(LADDER_OFS, d & 32'hf7, 1'b0, "ladder readback");
    apb(1'b1, 8'h10, 32'hff);
    check({31'h0, e}, 32'h1, "unmapped write");
    rd_chk(8'h10, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, STATUS_OFS, 32'hff);
    check({31'h0, e}, 32'h1, "status write");
    rd_chk(LADDER_OFS, d & 32'hf7, 1'b0, "ladder kept");
    $display("test registers done");
    set_lcd(1'b1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, LADDER_OFS, {24'h0, 2'(c), 2'(c), 4'h0});
      wt();
      check(32'(biasCtl.ladderPower), 32'(c), "power code");
    end
    // ladder is left at high power while the pin enables sweep
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, REFCTL_OFS, {26'h0, 3'(m), 3'b001});
      apb(1'b1, DISPCFG_OFS, {29'h0, 3'(m)});
      wt();
      check(32'(biasCtl.externalBiasPins), 32'(m), "pins");
      check(32'(biasCtl.ladderPower), 32'h3, "ladder with pins");
      check(32'(biasCtl.internalRefEnable), 32'h1, "ref on");
      check(32'(biasCtl.refFromFixedRef), 32'h0, "io source");
      check(32'(biasCtl.contrastEnable), 32'h1, "contrast on");
      check(32'(biasCtl.contrastTapSelect), 32'(m), "tap");
    end
    apb(1'b1, REFCTL_OFS, 32'h0);
    wt();
    check(32'(biasCtl.contrastEnable), 32'h0, "no reference");
    check(32'(biasCtl.internalRefEnable), 32'h0, "no reference");
    set_lcd(1'b0);
    $display("test static done");
    interval(1'b0, 3'd3, 1'b1, 18);
    interval(1'b1, 3'd7, 1'b1, 34);
    interval(1'b0, 3'd0, 1'b0, 4);
    // second reset in mid-run must bring the registers back
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(LADDER_OFS, 32'h0, 1'b0, "ladder after reset");
    rd_chk(STATUS_OFS, 32'h8, 1'b0, "status after reset");
    $display("test reset done");
    end_of_test();
  end
endmodule
